// ===== design/rxpc_pkg.sv
// Package of register map, field layout, reset values and carrier types for the receive path configuration block.
package rxpc_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0] RXPC_IDX_OUT_CTRL = 8'h0A;
  localparam logic [7:0] RXPC_IDX_EQ_LOSS  = 8'h0B;
  localparam logic [7:0] RXPC_IDX_SLC_WIN  = 8'h0C;
  localparam logic [7:0] RXPC_IDX_STATUS   = 8'h3F;

  // Reset values and writable bit masks.
  localparam logic [7:0] RXPC_RST_OUT_CTRL  = 8'h00;
  localparam logic [7:0] RXPC_RST_EQ_LOSS   = 8'h15;
  localparam logic [7:0] RXPC_RST_SLC_WIN   = 8'h18;
  localparam logic [7:0] RXPC_MASK_OUT_CTRL = 8'h1F;
  localparam logic [7:0] RXPC_MASK_EQ_LOSS  = 8'h5F;
  localparam logic [7:0] RXPC_MASK_SLC_WIN  = 8'h3F;

  // Field positions.
  localparam int RXPC_BIT_POWER_DOWN = 4;
  localparam int RXPC_BIT_POLARITY   = 3;
  localparam int RXPC_BIT_FALL_EDGE  = 2;
  localparam int RXPC_POS_MODE       = 0;
  localparam int RXPC_BIT_EQ_ENABLE  = 6;
  localparam int RXPC_POS_LOSS       = 0;
  localparam int RXPC_POS_THRESHOLD  = 4;
  localparam int RXPC_POS_WINDOW     = 2;
  localparam int RXPC_POS_GAIN       = 0;

  // Decode mode codes.
  localparam logic [1:0] RXPC_MODE_CODED  = 2'h0;
  localparam logic [1:0] RXPC_MODE_AMI    = 2'h1;
  localparam logic [1:0] RXPC_MODE_DUAL   = 2'h2;
  localparam logic [1:0] RXPC_MODE_SLICER = 2'h3;

  // Loss level saturation, dB scaling and slicer threshold percent scaling.
  localparam logic [4:0] RXPC_LOSS_MAX     = 5'h16;
  localparam logic [5:0] RXPC_LOSS_DECLARE = 6'h04;
  localparam logic [6:0] RXPC_THRESH_BASE  = 7'h28;
  localparam logic [6:0] RXPC_THRESH_STEP  = 7'h0A;

  // Decoder window depth in bits.
  localparam int RXPC_DEPTH = 8;

  // One received ternary symbol as two marks.
  typedef struct packed {
    logic pos;
    logic neg;
  } rxpc_sym_t;

  // Settings handed to the analog receiver.
  typedef struct packed {
    logic       power_down;
    logic       equalizer_enable;
    logic [4:0] signal_loss_level;
    logic [1:0] slicer_threshold;
    logic [1:0] equalizer_window;
    logic [1:0] monitor_gain;
  } rxpc_analog_cfg_t;

  // Outputs toward the framer.
  typedef struct packed {
    logic rx_clk;
    logic rx_data;
    logic rx_positive_rail_out;
    logic rx_negative_rail_out;
  } rxpc_framer_t;

endpackage : rxpc_pkg

// ===== design/rxpc_line_decoder.sv
// Line decoder that strips HDB3 or B8ZS substitution codes from a ternary symbol stream.
`timescale 1ns/1ps
module rxpc_line_decoder
  import rxpc_pkg::*;
(
  input  wire logic      hclk,
  input  wire logic      hresetn,
  input  wire logic      strobe,
  input  wire logic      flush,
  input  wire logic      subst_en,
  input  wire logic      t1_sel,
  input  wire rxpc_sym_t sym_in,
  output rxpc_sym_t      sym_out
);

  rxpc_sym_t win_r [RXPC_DEPTH];
  rxpc_sym_t win_nxt [RXPC_DEPTH];
  rxpc_sym_t shifted [RXPC_DEPTH];
  rxpc_sym_t out_nxt;
  logic      last_neg_r;
  logic      last_neg_nxt;
  logic      seen_r;
  logic      seen_nxt;

  // The window shifts by one symbol at every bit strobe, newest at index zero.
  generate
    for (genvar k = 0; k < RXPC_DEPTH; k++) begin : g_shift
      if (k == 0) begin : g_head
        assign shifted[k] = sym_in;
      end else begin : g_body
        assign shifted[k] = win_r[k-1];
      end
    end
  endgenerate

  // Substitutions are matched on entry, so the whole code is erased before any of it leaves.
  always_comb begin
    win_nxt      = win_r;
    out_nxt      = sym_out;
    last_neg_nxt = last_neg_r;
    seen_nxt     = seen_r;
    if (flush) begin
      for (int i = 0; i < RXPC_DEPTH; i++) begin
        win_nxt[i] = '0;
      end
      out_nxt      = '0;
      last_neg_nxt = 1'b0;
      seen_nxt     = 1'b0;
    end else if (strobe) begin
      win_nxt = shifted;
      out_nxt = win_r[RXPC_DEPTH-1];
      if (|sym_in) begin
        last_neg_nxt = sym_in.neg;
        seen_nxt     = 1'b1;
      end
      if (subst_en && t1_sel) begin
        // Eight zeros are sent as 000VB0VB; a lone stream cannot hold two such violations.
        if (!(|shifted[7]) && !(|shifted[6]) && !(|shifted[5]) && !(|shifted[2]) && (|shifted[4]) &&
            (shifted[3] == {shifted[4].neg, shifted[4].pos}) && (shifted[1] == shifted[3]) &&
            (shifted[0] == shifted[4])) begin
          win_nxt[4] = '0;
          win_nxt[3] = '0;
          win_nxt[1] = '0;
          win_nxt[0] = '0;
        end
      end else if (subst_en && (|sym_in) && !(|shifted[1]) && !(|shifted[2])) begin
        // Four zeros are sent as B00V or 000V, the V repeating the last pulse polarity.
        // With no mark since the flush there is no last polarity, so a first mark is never taken for a V.
        if (shifted[3] == sym_in) begin
          win_nxt[3] = '0;
          win_nxt[0] = '0;
        end else if (seen_r && !(|shifted[3]) && (sym_in.neg == last_neg_r)) begin
          win_nxt[0] = '0;
        end
      end
    end
  end

  // The decoder state registers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < RXPC_DEPTH; i++) begin
        win_r[i] <= '0;
      end
      sym_out    <= '0;
      last_neg_r <= 1'b0;
      seen_r     <= 1'b0;
    end else begin
      win_r      <= win_nxt;
      sym_out    <= out_nxt;
      last_neg_r <= last_neg_nxt;
      seen_r     <= seen_nxt;
    end
  end

endmodule : rxpc_line_decoder

// ===== design/rxpc_rx_path_config.sv
// Receive path configuration registers with an AHB-Lite slave and the receive output formatter.
`timescale 1ns/1ps
module rxpc_rx_path_config
  import rxpc_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        t1_mode,
  input  wire logic        line_in_tip,
  input  wire logic        line_in_ring,
  input  wire logic        cdr_bit_strobe,
  input  wire logic        cdr_half_strobe,
  output rxpc_analog_cfg_t analog_cfg,
  output rxpc_framer_t     framer_out
);

  // Bus slave states.
  typedef enum logic [1:0] {
    RXPC_ST_IDLE,
    RXPC_ST_WRITE,
    RXPC_ST_RD_WAIT,
    RXPC_ST_RD_DONE
  } rxpc_bus_state_t;

  rxpc_bus_state_t state_r;
  rxpc_bus_state_t state_nxt;
  logic [7:0]      addr_idx_r;
  logic [7:0]      addr_idx_nxt;
  logic            addr_ok_r;
  logic            addr_ok_nxt;
  logic [31:0]     hrdata_r;
  logic [31:0]     hrdata_nxt;
  logic [7:0]      out_ctrl_r;
  logic [7:0]      out_ctrl_nxt;
  logic [7:0]      eq_loss_r;
  logic [7:0]      eq_loss_nxt;
  logic [7:0]      slc_win_r;
  logic [7:0]      slc_win_nxt;
  logic [31:0]     status_word;
  logic [31:0]     read_mux;
  logic            take;

  // Decoded register fields.
  logic            power_down;
  logic            polarity_low;
  logic            fall_edge;
  logic [1:0]      decode_mode;
  logic [4:0]      loss_code;
  logic [4:0]      loss_eff;
  logic [5:0]      clear_db;
  logic [5:0]      declare_db;
  logic [1:0]      thresh_code;
  logic [6:0]      thresh_pct;

  // Receive datapath state.
  rxpc_sym_t       raw_sym;
  rxpc_sym_t       dec_sym;
  rxpc_sym_t       pend_r;
  rxpc_sym_t       pend_nxt;
  rxpc_framer_t    fr_r;
  rxpc_framer_t    fr_nxt;
  logic            update;
  logic            single_rail;
  logic            slicer_mode;

  // An address phase is taken only when the bus is ready and a transfer is real.
  assign take = hsel && hready && htrans[1];

  // Field views of the stored registers.
  assign power_down   = out_ctrl_r[RXPC_BIT_POWER_DOWN];
  assign polarity_low = out_ctrl_r[RXPC_BIT_POLARITY];
  assign fall_edge    = out_ctrl_r[RXPC_BIT_FALL_EDGE];
  assign decode_mode  = out_ctrl_r[RXPC_POS_MODE +: 2];
  assign loss_code    = eq_loss_r[RXPC_POS_LOSS +: 5];
  assign thresh_code  = slc_win_r[RXPC_POS_THRESHOLD +: 2];
  assign slicer_mode  = (decode_mode == RXPC_MODE_SLICER);
  assign single_rail  = (decode_mode == RXPC_MODE_CODED) || (decode_mode == RXPC_MODE_AMI);

  // Codes past the last table row behave as that row, so the levels stop moving.
  always_comb begin
    loss_eff   = (loss_code > RXPC_LOSS_MAX) ? RXPC_LOSS_MAX : loss_code;
    clear_db   = {loss_eff, 1'b0};
    declare_db = 6'({loss_eff, 1'b0} + RXPC_LOSS_DECLARE);
    thresh_pct = 7'(RXPC_THRESH_BASE + 7'(thresh_code) * RXPC_THRESH_STEP);
  end

  // The status word shows magnitudes in dB, the percent threshold and the live path setup.
  always_comb begin
    status_word        = '0;
    status_word[5:0]   = clear_db;
    status_word[13:8]  = declare_db;
    status_word[16]    = !power_down;
    status_word[17]    = fall_edge && !slicer_mode;
    status_word[19:18] = decode_mode;
    status_word[20]    = loss_code > RXPC_LOSS_MAX;
    status_word[30:24] = thresh_pct;
  end

  // Read multiplexer; reserved bits are never stored, so they read as zero.
  always_comb begin
    read_mux = '0;
    if (addr_ok_r) begin
      case (addr_idx_r)
        RXPC_IDX_OUT_CTRL: read_mux[7:0] = out_ctrl_r;
        RXPC_IDX_EQ_LOSS:  read_mux[7:0] = eq_loss_r;
        RXPC_IDX_SLC_WIN:  read_mux[7:0] = slc_win_r;
        RXPC_IDX_STATUS:   read_mux      = status_word;
        default:           read_mux      = '0;
      endcase
    end
  end

  // Bus slave next state; reads take one wait state so a write just before is always seen.
  always_comb begin
    state_nxt    = state_r;
    addr_idx_nxt = addr_idx_r;
    addr_ok_nxt  = addr_ok_r;
    hrdata_nxt   = hrdata_r;
    case (state_r)
      RXPC_ST_RD_WAIT: begin
        hrdata_nxt = read_mux;
        state_nxt  = RXPC_ST_RD_DONE;
      end
      RXPC_ST_IDLE,
      RXPC_ST_WRITE,
      RXPC_ST_RD_DONE: begin
        if (take) begin
          addr_idx_nxt = haddr[9:2];
          addr_ok_nxt  = (haddr[31:10] == '0) && (haddr[1:0] == 2'h0);
          state_nxt    = hwrite ? RXPC_ST_WRITE : RXPC_ST_RD_WAIT;
        end else begin
          state_nxt = RXPC_ST_IDLE;
        end
      end
      default: begin
        state_nxt = RXPC_ST_IDLE;
      end
    endcase
  end

  // Bus slave registers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r    <= RXPC_ST_IDLE;
      addr_idx_r <= 8'h00;
      addr_ok_r  <= 1'b0;
      hrdata_r   <= 32'h00000000;
    end else begin
      state_r    <= state_nxt;
      addr_idx_r <= addr_idx_nxt;
      addr_ok_r  <= addr_ok_nxt;
      hrdata_r   <= hrdata_nxt;
    end
  end

  // The slave never errors; only the read wait state pulls ready low.
  assign hreadyout = (state_r != RXPC_ST_RD_WAIT);
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  // Register writes land in the data phase; masking drops reserved bits.
  always_comb begin
    out_ctrl_nxt = out_ctrl_r;
    eq_loss_nxt  = eq_loss_r;
    slc_win_nxt  = slc_win_r;
    if ((state_r == RXPC_ST_WRITE) && addr_ok_r) begin
      case (addr_idx_r)
        RXPC_IDX_OUT_CTRL: out_ctrl_nxt = hwdata[7:0] & RXPC_MASK_OUT_CTRL;
        RXPC_IDX_EQ_LOSS:  eq_loss_nxt  = hwdata[7:0] & RXPC_MASK_EQ_LOSS;
        RXPC_IDX_SLC_WIN:  slc_win_nxt  = hwdata[7:0] & RXPC_MASK_SLC_WIN;
        default: begin
          out_ctrl_nxt = out_ctrl_r;
        end
      endcase
    end
  end

  // Configuration registers with their documented reset values.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_ctrl_r <= RXPC_RST_OUT_CTRL;
      eq_loss_r  <= RXPC_RST_EQ_LOSS;
      slc_win_r  <= RXPC_RST_SLC_WIN;
    end else begin
      out_ctrl_r <= out_ctrl_nxt;
      eq_loss_r  <= eq_loss_nxt;
      slc_win_r  <= slc_win_nxt;
    end
  end

  // Settings for the analog receiver come straight from register bits, except the loss level, which is the saturated code.
  always_comb begin
    analog_cfg.power_down        = power_down;
    analog_cfg.equalizer_enable  = eq_loss_r[RXPC_BIT_EQ_ENABLE];
    analog_cfg.signal_loss_level = loss_eff;
    analog_cfg.slicer_threshold  = thresh_code;
    analog_cfg.equalizer_window  = slc_win_r[RXPC_POS_WINDOW +: 2];
    analog_cfg.monitor_gain      = slc_win_r[RXPC_POS_GAIN +: 2];
  end

  // The slicer marks arrive already sampled into this clock domain.
  assign raw_sym.pos = line_in_tip;
  assign raw_sym.neg = line_in_ring;

  // Substitution removal runs only in the coded mode; AMI mode shares the same delay.
  rxpc_line_decoder u_decoder (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .strobe   (cdr_bit_strobe),
    .flush    (power_down || !single_rail),
    .subst_en (decode_mode == RXPC_MODE_CODED),
    .t1_sel   (t1_mode),
    .sym_in   (raw_sym),
    .sym_out  (dec_sym)
  );

  // Output data changes on the selected clock edge, or every cycle in slicer mode.
  always_comb begin
    if (slicer_mode) begin
      update = 1'b1;
    end else if (fall_edge) begin
      update = cdr_half_strobe;
    end else begin
      update = cdr_bit_strobe;
    end
  end

  // Each recovered bit is staged first, so both edge choices see the same bit.
  always_comb begin
    pend_nxt = pend_r;
    if (power_down) begin
      pend_nxt = '0;
    end else if (cdr_bit_strobe) begin
      pend_nxt = (decode_mode == RXPC_MODE_DUAL) ? raw_sym : dec_sym;
    end
  end

  // Framer outputs; unused outputs and a powered-down receiver rest at the inactive level.
  always_comb begin
    fr_nxt = fr_r;
    if (power_down) begin
      fr_nxt.rx_clk               = 1'b0;
      fr_nxt.rx_data              = polarity_low;
      fr_nxt.rx_positive_rail_out = polarity_low;
      fr_nxt.rx_negative_rail_out = polarity_low;
    end else begin
      // Slicer mode has no recovered clock, so the clock is the OR of the raw marks.
      if (slicer_mode) begin
        fr_nxt.rx_clk = raw_sym.pos | raw_sym.neg;
      end else if (cdr_bit_strobe) begin
        fr_nxt.rx_clk = 1'b1;
      end else if (cdr_half_strobe) begin
        fr_nxt.rx_clk = 1'b0;
      end
      if (update) begin
        case (decode_mode)
          RXPC_MODE_CODED,
          RXPC_MODE_AMI: begin
            fr_nxt.rx_data              = (pend_r.pos | pend_r.neg) ^ polarity_low;
            fr_nxt.rx_positive_rail_out = polarity_low;
            fr_nxt.rx_negative_rail_out = polarity_low;
          end
          RXPC_MODE_DUAL: begin
            fr_nxt.rx_data              = polarity_low;
            fr_nxt.rx_positive_rail_out = pend_r.pos ^ polarity_low;
            fr_nxt.rx_negative_rail_out = pend_r.neg ^ polarity_low;
          end
          default: begin
            fr_nxt.rx_data              = polarity_low;
            fr_nxt.rx_positive_rail_out = raw_sym.pos ^ polarity_low;
            fr_nxt.rx_negative_rail_out = raw_sym.neg ^ polarity_low;
          end
        endcase
      end
    end
  end

  // Datapath registers; outputs reset to the active-high idle level.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_r <= '0;
      fr_r   <= '0;
    end else begin
      pend_r <= pend_nxt;
      fr_r   <= fr_nxt;
    end
  end

  assign framer_out = fr_r;

  // The word size is not checked: every access acts on the whole register word.
  logic unused_size;
  assign unused_size = ^hsize;

endmodule : rxpc_rx_path_config

// ===== testbench/rxpc_rx_path_config_checker.sv
// Concurrent checks of register effects and receive output timing of the receive path configuration block.
`timescale 1ns/1ps
module rxpc_rx_path_config_checker
  import rxpc_pkg::*;
(
  input wire logic             hclk,
  input wire logic             hresetn,
  input wire logic             hsel,
  input wire logic [31:0]      haddr,
  input wire logic [1:0]       htrans,
  input wire logic             hwrite,
  input wire logic [2:0]       hsize,
  input wire logic [31:0]      hwdata,
  input wire logic             hready,
  input wire logic             hreadyout,
  input wire logic             hresp,
  input wire logic [31:0]      hrdata,
  input wire logic             t1_mode,
  input wire logic             line_in_tip,
  input wire logic             line_in_ring,
  input wire logic             cdr_bit_strobe,
  input wire logic             cdr_half_strobe,
  input wire rxpc_analog_cfg_t analog_cfg,
  input wire rxpc_framer_t     framer_out
);
  logic       wr_r;
  logic [7:0] wa_r;
  logic [4:0] ctl_r;
  logic       take;
  logic       wdat;
  logic       slc;

  // Address phase taken, write data phase ending, and slicer mode with the receiver on.
  assign take = hsel & hready & htrans[1];
  assign wdat = wr_r & hready;
  assign slc  = (ctl_r[1:0] == 2'h3) & ~ctl_r[4];

  // Shadow of the control register, so output checks know the mode and polarity in force.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_r  <= 1'b0;
      wa_r  <= 8'h00;
      ctl_r <= 5'h00;
    end else begin
      wr_r <= take ? hwrite : (wr_r & ~hready);
      if (take) begin
        wa_r <= haddr[7:0];
      end
      if (wdat && wa_r == 8'h28) begin
        ctl_r <= hwdata[4:0];
      end
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_pd_write: assert property (wdat && wa_r == 8'h28 |=> analog_cfg.power_down == $past(hwdata[4]))
    else $error("power down setting does not follow the written word");
  a_pd_quiet: assert property (analog_cfg.power_down && $past(analog_cfg.power_down) &&
    $stable(ctl_r) |-> !framer_out.rx_clk && framer_out.rx_data == ctl_r[3])
    else $error("powered down outputs are not at rest");
  a_eq_write: assert property (wdat && wa_r == 8'h2C |=>
    analog_cfg.equalizer_enable == $past(hwdata[6]))
    else $error("equalizer enable does not follow the written word");
  a_loss_write: assert property (wdat && wa_r == 8'h2C |=> analog_cfg.signal_loss_level ==
    (($past(hwdata[4:0]) > 5'h16) ? 5'h16 : $past(hwdata[4:0])))
    else $error("loss level is not the written code saturated");
  a_thr_write: assert property (wdat && wa_r == 8'h30 |=>
    analog_cfg.slicer_threshold == $past(hwdata[5:4]))
    else $error("slicer threshold does not follow the written word");
  a_win_gain: assert property (wdat && wa_r == 8'h30 |=>
    {analog_cfg.equalizer_window, analog_cfg.monitor_gain} == $past(hwdata[3:0]))
    else $error("window or gain does not follow the written word");
  a_read_wait: assert property (take && !hwrite |=> !hreadyout && hresp == 1'b0 ##1 hreadyout)
    else $error("read answer does not come after one wait state");
  a_slicer_rails: assert property (slc && $stable(ctl_r) |->
    {framer_out.rx_positive_rail_out, framer_out.rx_negative_rail_out} ==
    ({$past(line_in_tip), $past(line_in_ring)} ^ {2{ctl_r[3]}}))
    else $error("slicer rails are not the previous line marks");
  a_slicer_clk: assert property (slc && $stable(ctl_r) |->
    framer_out.rx_clk == $past(line_in_tip | line_in_ring))
    else $error("slicer clock is not the previous mark");
endmodule : rxpc_rx_path_config_checker

// ===== testbench/rxpc_framer_model.sv
// Framer-side receiver model that counts single rail ones taken at the falling receive clock.
`timescale 1ns/1ps
module rxpc_framer_model
  import rxpc_pkg::*;
(
  input  wire logic         hclk,
  input  wire logic         clr,
  input  wire rxpc_framer_t rx_in,
  output int                ones
);
  logic clk_q = 1'b0;

  // Sampling half a bit after the update edge keeps the count clear of the data transition.
  always @(posedge hclk) begin
    clk_q <= rx_in.rx_clk;
    if (clr) begin
      ones <= 0;
    end else if (clk_q && !rx_in.rx_clk) begin
      ones <= ones + int'(rx_in.rx_data);
    end
  end
endmodule : rxpc_framer_model

// ===== testbench/rxpc_rx_path_config_tb_top.sv
// Top testbench of the receive path configuration block with bus tasks, line stimulus and checks.
`timescale 1ns/1ps
module rxpc_rx_path_config_tb_top
  import rxpc_pkg::*;
;
  localparam logic [31:0] A_CTL = 32'h0000_0028;
  localparam logic [31:0] A_EQ  = 32'h0000_002C;
  localparam logic [31:0] A_SW  = 32'h0000_0030;
  localparam logic [31:0] A_ST  = 32'h0000_00FC;
  logic             hclk;
  logic             hresetn;
  logic             hsel;
  logic [31:0]      haddr;
  logic [1:0]       htrans;
  logic             hwrite;
  logic [2:0]       hsize;
  logic [31:0]      hwdata;
  logic             hreadyout;
  logic             hresp;
  logic [31:0]      hrdata;
  logic             t1_mode;
  logic             line_in_tip;
  logic             line_in_ring;
  logic             cdr_bit_strobe;
  logic             cdr_half_strobe;
  logic             clr;
  rxpc_analog_cfg_t analog_cfg;
  rxpc_framer_t     framer_out;
  logic [31:0]      q;
  logic [1:0]       k;
  logic [5:0]       e;
  int               ones;
  int               n_mismatch = 0;
  int               compares = 0;
  logic [7:0]       rstv [3] = '{8'h00, 8'h15, 8'h18};
  logic [7:0]       mask [3] = '{8'h1F, 8'h5F, 8'h3F};
  logic [31:0]      adr [3] = '{A_CTL, A_EQ, A_SW};
  logic [4:0]       lc [5] = '{5'h00, 5'h01, 5'h15, 5'h16, 5'h1F};
  int               expo [4] = '{3, 4, 2, 6};
  logic [1:0]       seq [2][10] = '{'{2'h2, 2'h1, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h0, 2'h0, 2'h0},
                                    '{2'h2, 2'h0, 2'h0, 2'h0, 2'h2, 2'h1, 2'h0, 2'h1, 2'h2, 2'h1}};

  // With a single slave its ready output closes the bus ready loop.
  rxpc_rx_path_config dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .t1_mode(t1_mode), .line_in_tip(line_in_tip), .line_in_ring(line_in_ring),
    .cdr_bit_strobe(cdr_bit_strobe), .cdr_half_strobe(cdr_half_strobe), .analog_cfg(analog_cfg),
    .framer_out(framer_out)
  );
  rxpc_framer_model u_framer (.hclk(hclk), .clr(clr), .rx_in(framer_out), .ones(ones));

  // Each phase holds until ready is seen high at a rising edge; read data is taken at that same edge.
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : ahb

  // Line symbols with a bit strobe every fourth cycle and the half strobe between.
  task automatic run(input logic [1:0] s, input int first, input int n);
    for (int i = first; i < first + n; i++) begin
      @(posedge hclk);
      line_in_tip     <= s[1];
      line_in_ring    <= s[0];
      cdr_bit_strobe  <= (i % 4 == 0);
      cdr_half_strobe <= (i % 4 == 2);
    end
    @(negedge hclk);
  endtask : run

  task automatic chk(input string nm, input logic [31:0] xp, input logic [31:0] got);
    compares++;
    if (got !== xp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, xp, got);
    end
  endtask : chk

  task automatic close_out;
    $display("Mismatches %0d of %0d compares", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  // A 5 ns clock.
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  // The whole sequence needs under a thousand cycles; a hang is cut well beyond that.
  initial begin
    repeat (20000) @(posedge hclk);
    n_mismatch++;
    close_out();
  end

  // Main sequence of register and receive stream scenarios.
  initial begin
    hresetn         = 1'b0;
    hsel            = 1'b1;
    haddr           = 32'h0;
    htrans          = 2'h0;
    hwrite          = 1'b0;
    hsize           = 3'h2;
    hwdata          = 32'h0;
    t1_mode         = 1'b0;
    line_in_tip     = 1'b0;
    line_in_ring    = 1'b0;
    cdr_bit_strobe  = 1'b0;
    cdr_half_strobe = 1'b0;
    clr             = 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    chk("analog reset", 32'h0558, {19'h0, analog_cfg});
    foreach (adr[i]) begin
      ahb(1'b0, adr[i], 32'h0, q);
      chk("reset value", {24'h0, rstv[i]}, q);
      ahb(1'b1, adr[i], 32'hFFFF_FFFF, q);
      ahb(1'b0, adr[i], 32'h0, q);
      chk("reserved bits", {24'h0, mask[i]}, q);
    end
    chk("analog all ones", 32'h1DBF, {19'h0, analog_cfg});
    ahb(1'b1, 32'h34, 32'hFFFF_FFFF, q);
    ahb(1'b0, 32'h34, 32'h0, q);
    chk("unmapped word", 32'h0, q);
    foreach (lc[i]) begin
      ahb(1'b1, A_EQ, {27'h0, lc[i]}, q);
      ahb(1'b0, A_ST, 32'h0, q);
      e = (lc[i] > 5'h16) ? 6'h2C : {lc[i], 1'b0};
      chk("loss levels", {18'h0, e + 6'h04, 2'h0, e}, {18'h0, q[13:0]});
    end
    for (int c = 0; c < 4; c++) begin
      k = c[1:0];
      ahb(1'b1, A_SW, {26'h0, k, k, k}, q);
      ahb(1'b0, A_ST, 32'h0, q);
      chk("threshold percent", 32'(32'h28 + 32'h0A * c), {25'h0, q[30:24]});
      chk("slicer window gain", {26'h0, k, k, k}, {26'h0, analog_cfg[5:0]});
      ahb(1'b1, A_CTL, {29'h0, 1'b1, k}, q);
      ahb(1'b0, A_ST, 32'h0, q);
      chk("mode status", {28'h0, k, k != 2'h3, 1'b1}, {28'h0, q[19:16]});
    end
    ahb(1'b1, A_CTL, 32'h18, q);
    run(2'h2, 0, 8);
    chk("powered down outputs", 32'h7, {28'h0, framer_out});
    ahb(1'b0, A_ST, 32'h0, q);
    chk("receiver on flag", 32'h0, {31'h0, q[16]});
    // Dual rail: a mark leaves at the next strobe on the rising setting and at the half before it on the falling.
    for (int c = 0; c < 4; c++) begin
      k = c[1:0];
      ahb(1'b1, A_CTL, {28'h0, k, 2'h2}, q);
      run(2'h0, 0, 8);
      run(2'h2, 0, 4);
      run(2'h0, 0, 3);
      chk("rail after strobe", {31'h0, ~k[1]}, {31'h0, framer_out.rx_positive_rail_out});
      run(2'h0, 3, 2);
      chk("rails after half", {30'h0, k[1] ^ ~k[0], k[1]}, {30'h0, framer_out[1:0]});
      run(2'h0, 5, 3);
    end
    for (int c = 0; c < 2; c++) begin
      k = c[1:0];
      ahb(1'b1, A_CTL, {28'h0, k[0], 3'h7}, q);
      run(2'h1, 0, 4);
      chk("slicer outputs", {29'h0, 1'b1, k[0], ~k[0]}, {29'h0, framer_out[3], framer_out[1:0]});
      run(2'h0, 0, 4);
    end
    // Substitution codes count as zeros when removed and as ones under plain AMI.
    for (int c = 0; c < 4; c++) begin
      k = c[1:0];
      @(posedge hclk);
      t1_mode <= k[1];
      ahb(1'b1, A_CTL, {31'h0, k[0]}, q);
      run(2'h0, 0, 48);
      @(posedge hclk);
      clr <= 1'b1;
      @(posedge hclk);
      clr <= 1'b0;
      for (int i = 0; i < 10; i++) begin
        run(seq[k[1]][i], 0, 4);
      end
      run(2'h0, 0, 48);
      chk("decoded ones", expo[c], ones);
      chk("unused rail", 32'h0, {31'h0, framer_out.rx_positive_rail_out});
    end
    close_out();
  end
endmodule : rxpc_rx_path_config_tb_top

bind rxpc_rx_path_config rxpc_rx_path_config_checker u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .t1_mode(t1_mode), .line_in_tip(line_in_tip), .line_in_ring(line_in_ring),
  .cdr_bit_strobe(cdr_bit_strobe), .cdr_half_strobe(cdr_half_strobe), .analog_cfg(analog_cfg),
  .framer_out(framer_out)
);
